// file: pkg/ccmk_consts.svh
// Register map, field positions, reset values and fixed figures of the packet encryptor.
//
// Behaviour
// - Keystream task runs generation, then keystream-done event.
// - Key, counter, vector come from config structure.
// - Keystream written to scratch area, reused later.
// - Default length mode gives 27-byte keystream.
// - Extended mode length from limit register, max 251.
// - Cipher task in encrypt mode ends with done event.
// - Reads plaintext, encrypts, appends four-byte integrity tag.
// - Length field plus four, packet stored at output.
// - Zero-length packet copied unchanged, no tag.
// - Length field width selectable through mode register.
// - AES-128 keystream XOR data, tag in same pass.
// - Own memory master loads material, moves packet data.
// - Config: key 0, counter 16, direction 24, vector 25.
// - Packet: header 0, length 1, spare 2, payload 3.
// - Memory contention during encryption raises error event.
// - All memory accesses finished before done events.
`ifndef CCMK_CONSTS_SVH
`define CCMK_CONSTS_SVH

`define CCMK_OFS_TASK 8'h00
`define CCMK_OFS_EVENTS 8'h04
`define CCMK_OFS_SHORTCUT 8'h08
`define CCMK_OFS_MODE 8'h0c
`define CCMK_OFS_CFGPTR 8'h10
`define CCMK_OFS_SCRPTR 8'h14
`define CCMK_OFS_INPUT_POINTER 8'h18
`define CCMK_OFS_OUTPUT_POINTER 8'h1c
`define CCMK_OFS_KSLIMIT 8'h20
`define CCMK_OFS_STATUS 8'h24

`define CCMK_TASK_KS_BIT 0
`define CCMK_TASK_CIPHER_BIT 1
`define CCMK_EV_KS_BIT 0
`define CCMK_EV_CIPHER_BIT 1
`define CCMK_EV_ERR_BIT 2
`define CCMK_MODE_DEC_BIT 0
`define CCMK_MODE_EXT_BIT 1
`define CCMK_MODE_WIDE_BIT 2

`define CCMK_KSLIMIT_RST 8'hfb
`define CCMK_KS_MAX_LEN 8'hfb
`define CCMK_KS_DEFAULT_LEN 8'h1b
`define CCMK_LEN_MASK_NARROW 8'h1f
`define CCMK_TAG_LEN 8'h04
`define CCMK_TAG_COUNT 5'h04
`define CCMK_HDR_COUNT 5'h03
`define CCMK_PAYLOAD_OFS 32'h00000003
`define CCMK_CFG_CHUNK 5'h10
`define CCMK_CFG_TAIL 5'h01
`define CCMK_CFG_LAST_IDX 2'h2
`define CCMK_BLK_BYTES 5'h10
`define CCMK_BLK_ROUND 9'h00f
`define CCMK_SCR_KS_OFS 32'h00000010
`define CCMK_A_FLAGS 8'h01
`define CCMK_B0_FLAGS 8'h49
`define CCMK_AAD_LEN 16'h0001
`define CCMK_HDR_MASK 8'he3
`define CCMK_STALL_LIMIT 8'h40
`define CCMK_AES_POLY 8'h1b
`define CCMK_AES_AFFINE 8'h63
`define CCMK_AES_RCON0 8'h01
`define CCMK_AES_LAST 4'ha

`endif

// file: pkg/ccmk_pkg.sv
// State types of the packet encryptor, its memory mover and its AES core.
package ccmk_pkg;

  typedef enum logic [13:0] {
    ST_IDLE = 14'h0001, ST_CFG = 14'h0002, ST_KSA = 14'h0004, ST_KSW = 14'h0008,
    ST_HDR = 14'h0010, ST_MB0 = 14'h0020, ST_MB1 = 14'h0040, ST_PRD = 14'h0080,
    ST_PAES = 14'h0100, ST_KRD = 14'h0200, ST_CWR = 14'h0400, ST_S0RD = 14'h0800,
    ST_TWR = 14'h1000, ST_HWR = 14'h2000
  } ccmk_main_state_t;

  typedef enum logic [2:0] {MV_IDLE = 3'h1, MV_REQ = 3'h2, MV_WAIT = 3'h4} ccmk_mv_state_t;

  typedef struct packed {
    ccmk_main_state_t st;
    logic go;
    logic op;
    logic [1:0] cfgIdx;
    logic [127:0] key;
    logic [103:0] nonce;
    logic [4:0] blk;
    logic [4:0] nblk;
    logic [7:0] len;
    logic [23:0] hdr;
    logic [127:0] mac;
    logic [127:0] dat;
    logic [31:0] cfgPtr;
    logic [31:0] scrPtr;
    logic [31:0] input_pointer;
    logic [31:0] output_pointer;
    logic [7:0] ksLimit;
    logic modeDec;
    logic modeExt;
    logic modeWide;
    logic shortcut;
    logic evKs;
    logic evCr;
    logic evErr;
    logic [31:0] rdData;
  } ccmk_main_t;

  typedef struct packed {
    ccmk_mv_state_t st;
    logic write;
    logic [31:0] addr;
    logic [4:0] cnt;
    logic [4:0] idx;
    logic [127:0] buffer;
    logic [7:0] stall;
    logic done;
    logic err;
  } ccmk_mv_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] rnd;
    logic [7:0] rcon;
    logic [127:0] st;
    logic [127:0] key;
  } ccmk_aes_t;

endpackage

// file: src/ccmk_aes_core.sv
// Iterative AES-128 encryptor, one round per clock, round keys expanded on the fly.
`timescale 1ns/10ps
`include "ccmk_consts.svh"
module ccmk_aes_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [127:0] blockIn,
  input wire logic [127:0] keyIn,
  output logic done,
  output logic [127:0] blockOut
);
  import ccmk_pkg::*;
  ccmk_aes_t r_reg, r_next;

  function automatic logic [7:0] xt(input logic [7:0] b);
    return {b[6:0], 1'b0} ^ (b[7] ? `CCMK_AES_POLY : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // The S-box is computed as inverse plus affine map, trading area for a table-free design.
  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] p;
    p = a;
    for (int i = 0; i < 6; i++) p = gmul(gmul(p, p), a);
    p = gmul(p, p);
    return p ^ {p[6:0], p[7]} ^ {p[5:0], p[7:6]} ^ {p[4:0], p[7:5]} ^ {p[3:0], p[7:4]}
      ^ `CCMK_AES_AFFINE;
  endfunction

  function automatic logic [127:0] round(input logic [127:0] s, input logic last);
    logic [127:0] t;
    logic [127:0] m;
    logic [7:0] a0, a1, a2, a3;
    for (int k = 0; k < 16; k++) t[8*(15-k) +: 8] = sb(s[8*(15-(4*(((k/4)+(k%4))%4)+(k%4))) +: 8]);
    for (int c = 0; c < 4; c++) begin
      a0 = t[8*(15-4*c) +: 8];
      a1 = t[8*(14-4*c) +: 8];
      a2 = t[8*(13-4*c) +: 8];
      a3 = t[8*(12-4*c) +: 8];
      m[8*(15-4*c) +: 8] = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
      m[8*(14-4*c) +: 8] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
      m[8*(13-4*c) +: 8] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
      m[8*(12-4*c) +: 8] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
    end
    return last ? t : m;
  endfunction

  function automatic logic [127:0] expand(input logic [127:0] k, input logic [7:0] rc);
    logic [31:0] t;
    logic [127:0] n;
    t = {sb(k[23:16]) ^ rc, sb(k[15:8]), sb(k[7:0]), sb(k[31:24])};
    n[127:96] = k[127:96] ^ t;
    n[95:64] = k[95:64] ^ n[127:96];
    n[63:32] = k[63:32] ^ n[95:64];
    n[31:0] = k[31:0] ^ n[63:32];
    return n;
  endfunction

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (start) begin
      r_next.st = blockIn ^ keyIn;
      r_next.key = keyIn;
      r_next.rnd = 4'h1;
      r_next.rcon = `CCMK_AES_RCON0;
      r_next.busy = 1'b1;
    end else if (r_reg.busy) begin
      r_next.key = expand(r_reg.key, r_reg.rcon);
      r_next.st = round(r_reg.st, r_reg.rnd == `CCMK_AES_LAST) ^ r_next.key;
      r_next.rcon = xt(r_reg.rcon);
      r_next.rnd = r_reg.rnd + 4'h1;
      if (r_reg.rnd == `CCMK_AES_LAST) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) r_reg <= '0;
    else r_reg <= r_next;
  end

  assign done = r_reg.done;
  assign blockOut = r_reg.st;
endmodule

// file: src/ccmk_mem_mover.sv
// Byte-wide memory master that reads or writes up to sixteen bytes as one block.
`timescale 1ns/10ps
`include "ccmk_consts.svh"
module ccmk_mem_mover (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic write,
  input wire logic [31:0] addr,
  input wire logic [4:0] count,
  input wire logic [127:0] wrData,
  output logic done,
  output logic stallErr,
  output logic [127:0] rdData,
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memGnt,
  input wire logic memRvalid,
  input wire logic [7:0] memRdata
);
  import ccmk_pkg::*;
  ccmk_mv_t r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.err = 1'b0;
    case (r_reg.st)
      MV_IDLE: begin
        if (start) begin
          r_next = '{st: MV_REQ, write: write, addr: addr, cnt: count, idx: 5'h00,
            buffer: write ? wrData : 128'h0, stall: 8'h00, done: 1'b0, err: 1'b0};
        end
      end
      MV_REQ: begin
        if (memGnt) begin
          r_next.stall = 8'h00;
          if (r_reg.write) begin
            r_next.buffer = {r_reg.buffer[119:0], 8'h00};
            r_next.addr = r_reg.addr + 32'h1;
            r_next.idx = r_reg.idx + 5'h01;
            if (r_next.idx == r_reg.cnt) begin
              r_next.st = MV_IDLE;
              r_next.done = 1'b1;
            end
          end else begin
            r_next.st = MV_WAIT;
          end
        end else if (r_reg.stall != `CCMK_STALL_LIMIT) begin
          r_next.stall = r_reg.stall + 8'h01;
          // A starved bus is reported once per stall, not every cycle of it.
          r_next.err = (r_next.stall == `CCMK_STALL_LIMIT);
        end
      end
      MV_WAIT: begin
        if (memRvalid) begin
          r_next.buffer[{~r_reg.idx[3:0], 3'b000} +: 8] = memRdata;
          r_next.addr = r_reg.addr + 32'h1;
          r_next.idx = r_reg.idx + 5'h01;
          r_next.st = MV_REQ;
          if (r_next.idx == r_reg.cnt) begin
            r_next.st = MV_IDLE;
            r_next.done = 1'b1;
          end
        end
      end
      default: r_next.st = MV_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) r_reg <= '{st: MV_IDLE, default: '0};
    else r_reg <= r_next;
  end

  assign done = r_reg.done;
  assign stallErr = r_reg.err;
  assign rdData = r_reg.buffer;
  assign memReq = (r_reg.st == MV_REQ);
  assign memWrite = r_reg.write;
  assign memAddr = r_reg.addr;
  assign memWdata = r_reg.buffer[127:120];
endmodule

// file: src/ccmk_top.sv
// Packet encryptor top: registers, task sequencing, keystream and packet encryption.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "ccmk_consts.svh"
module ccmk_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic memReq,
  output logic memWrite,
  output logic [31:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic memGnt,
  input wire logic memRvalid,
  input wire logic [7:0] memRdata,
  output logic keystreamDoneEvent,
  output logic cipherDoneEvent,
  output logic errorEvent
);
  import ccmk_pkg::*;

  localparam ccmk_main_t MAIN_RST = '{st: ST_IDLE, ksLimit: `CCMK_KSLIMIT_RST, default: '0};

  logic [1:0] rstSync_reg;
  logic rst_n;
  ccmk_main_t r_reg, r_next;

  logic mvStart;
  logic mvWrite;
  logic [31:0] mvAddr;
  logic [4:0] mvCount;
  logic [127:0] mvWdata;
  logic mvDone;
  logic mvStall;
  logic [127:0] mvRdata;
  logic aesStart;
  logic [127:0] aesIn;
  logic aesDone;
  logic [127:0] aesOut;

  logic isMv;
  logic isAes;
  logic unitDone;
  logic [7:0] lenMask;
  logic [7:0] ksLen;
  logic [8:0] ksRound;
  logic [7:0] remain;
  logic [4:0] chunk;
  logic [31:0] blkOfs;
  logic [7:0] outLen;
  logic ksTrig;
  logic cipherTrig;
  logic evKsSet;
  logic evCrSet;
  logic evErrSet;
  logic evWr;

  // Reset is asserted at once and released two edges after the pin rises.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rstSync_reg <= 2'b00;
    else rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rst_n = rstSync_reg[1];

  ccmk_mem_mover mover (
    .clock(clock),
    .rst_n(rst_n),
    .start(mvStart),
    .write(mvWrite),
    .addr(mvAddr),
    .count(mvCount),
    .wrData(mvWdata),
    .done(mvDone),
    .stallErr(mvStall),
    .rdData(mvRdata),
    .memReq(memReq),
    .memWrite(memWrite),
    .memAddr(memAddr),
    .memWdata(memWdata),
    .memGnt(memGnt),
    .memRvalid(memRvalid),
    .memRdata(memRdata)
  );

  ccmk_aes_core aes (
    .clock(clock),
    .rst_n(rst_n),
    .start(aesStart),
    .blockIn(aesIn),
    .keyIn(r_reg.key),
    .done(aesDone),
    .blockOut(aesOut)
  );

  always_comb begin
    r_next = r_reg;
    mvWrite = 1'b0;
    mvAddr = 32'h0;
    mvCount = 5'h00;
    mvWdata = r_reg.dat;
    aesIn = r_reg.mac;
    isMv = 1'b0;
    isAes = 1'b0;
    evKsSet = 1'b0;
    evCrSet = 1'b0;
    lenMask = (r_reg.modeWide | r_reg.modeExt) ? 8'hff : `CCMK_LEN_MASK_NARROW;
    ksLen = r_reg.modeExt ? r_reg.ksLimit : `CCMK_KS_DEFAULT_LEN;
    ksRound = {1'b0, ksLen} + `CCMK_BLK_ROUND;
    remain = r_reg.len - {r_reg.blk[3:0], 4'h0};
    chunk = (remain > {3'h0, `CCMK_BLK_BYTES}) ? `CCMK_BLK_BYTES : remain[4:0];
    blkOfs = {23'h0, r_reg.blk, 4'h0};
    outLen = (r_reg.hdr[15:8] & ~lenMask) | ((r_reg.len + `CCMK_TAG_LEN) & lenMask);
    if (r_reg.len == 8'h00) outLen = r_reg.hdr[15:8];
    ksTrig = regWr && (regAddr == `CCMK_OFS_TASK) && regWdata[`CCMK_TASK_KS_BIT];
    cipherTrig = regWr && (regAddr == `CCMK_OFS_TASK) && regWdata[`CCMK_TASK_CIPHER_BIT];
    unitDone = r_reg.go && (mvDone || aesDone);

    case (r_reg.st)
      ST_IDLE: begin
        // Tasks that arrive while an operation runs are dropped.
        if (ksTrig) begin
          r_next.st = ST_CFG;
          r_next.op = 1'b0;
          r_next.cfgIdx = 2'h0;
        end else if (cipherTrig && !r_reg.modeDec) begin
          r_next.st = ST_CFG;
          r_next.op = 1'b1;
          r_next.cfgIdx = 2'h0;
        end
      end
      ST_CFG: begin
        isMv = 1'b1;
        mvAddr = r_reg.cfgPtr + {26'h0, r_reg.cfgIdx, 4'h0};
        mvCount = (r_reg.cfgIdx == `CCMK_CFG_LAST_IDX) ? `CCMK_CFG_TAIL : `CCMK_CFG_CHUNK;
        if (unitDone) begin
          r_next.cfgIdx = r_reg.cfgIdx + 2'h1;
          case (r_reg.cfgIdx)
            2'h0: r_next.key = mvRdata;
            2'h1: r_next.nonce[103:8] = {mvRdata[127:96], mvRdata[56], mvRdata[94:88],
              mvRdata[55:0]};
            default: begin
              r_next.nonce[7:0] = mvRdata[127:120];
              r_next.blk = 5'h00;
              r_next.nblk = ksRound[8:4];
              r_next.st = r_reg.op ? ST_HDR : ST_KSA;
            end
          endcase
        end
      end
      ST_KSA: begin
        isAes = 1'b1;
        aesIn = {`CCMK_A_FLAGS, r_reg.nonce, 11'h000, r_reg.blk};
        if (unitDone) begin
          r_next.dat = aesOut;
          r_next.st = ST_KSW;
        end
      end
      ST_KSW: begin
        isMv = 1'b1;
        mvWrite = 1'b1;
        mvAddr = r_reg.scrPtr + blkOfs;
        mvCount = `CCMK_BLK_BYTES;
        if (unitDone) begin
          r_next.blk = r_reg.blk + 5'h01;
          r_next.st = ST_KSA;
          if (r_reg.blk == r_reg.nblk) begin
            evKsSet = 1'b1;
            r_next.st = ST_IDLE;
            if (r_reg.shortcut && !r_reg.modeDec) begin
              r_next.st = ST_CFG;
              r_next.op = 1'b1;
              r_next.cfgIdx = 2'h0;
            end
          end
        end
      end
      ST_HDR: begin
        isMv = 1'b1;
        mvAddr = r_reg.input_pointer;
        mvCount = `CCMK_HDR_COUNT;
        if (unitDone) begin
          r_next.hdr = mvRdata[127:104];
          r_next.len = mvRdata[119:112] & lenMask;
          r_next.st = ((mvRdata[119:112] & lenMask) == 8'h00) ? ST_HWR : ST_MB0;
        end
      end
      ST_MB0: begin
        isAes = 1'b1;
        aesIn = {`CCMK_B0_FLAGS, r_reg.nonce, 8'h00, r_reg.len};
        if (unitDone) begin
          r_next.mac = aesOut;
          r_next.st = ST_MB1;
        end
      end
      ST_MB1: begin
        isAes = 1'b1;
        aesIn = r_reg.mac ^ {`CCMK_AAD_LEN, r_reg.hdr[23:16] & `CCMK_HDR_MASK, 104'h0};
        if (unitDone) begin
          r_next.mac = aesOut;
          r_next.blk = 5'h00;
          r_next.st = ST_PRD;
        end
      end
      ST_PRD: begin
        isMv = 1'b1;
        mvAddr = r_reg.input_pointer + `CCMK_PAYLOAD_OFS + blkOfs;
        mvCount = chunk;
        if (unitDone) begin
          r_next.dat = mvRdata;
          r_next.st = ST_PAES;
        end
      end
      ST_PAES: begin
        isAes = 1'b1;
        aesIn = r_reg.mac ^ r_reg.dat;
        if (unitDone) begin
          r_next.mac = aesOut;
          r_next.st = ST_KRD;
        end
      end
      ST_KRD: begin
        isMv = 1'b1;
        mvAddr = r_reg.scrPtr + `CCMK_SCR_KS_OFS + blkOfs;
        mvCount = chunk;
        if (unitDone) begin
          r_next.dat = r_reg.dat ^ mvRdata;
          r_next.st = ST_CWR;
        end
      end
      ST_CWR: begin
        isMv = 1'b1;
        mvWrite = 1'b1;
        mvAddr = r_reg.output_pointer + `CCMK_PAYLOAD_OFS + blkOfs;
        mvCount = chunk;
        if (unitDone) begin
          r_next.blk = r_reg.blk + 5'h01;
          r_next.st = (remain <= {3'h0, `CCMK_BLK_BYTES}) ? ST_S0RD : ST_PRD;
        end
      end
      ST_S0RD: begin
        isMv = 1'b1;
        mvAddr = r_reg.scrPtr;
        mvCount = `CCMK_TAG_COUNT;
        if (unitDone) begin
          r_next.dat = {mvRdata[127:96] ^ r_reg.mac[127:96], 96'h0};
          r_next.st = ST_TWR;
        end
      end
      ST_TWR: begin
        isMv = 1'b1;
        mvWrite = 1'b1;
        mvAddr = r_reg.output_pointer + `CCMK_PAYLOAD_OFS + {24'h0, r_reg.len};
        mvCount = `CCMK_TAG_COUNT;
        if (unitDone) r_next.st = ST_HWR;
      end
      ST_HWR: begin
        isMv = 1'b1;
        mvWrite = 1'b1;
        mvAddr = r_reg.output_pointer;
        mvCount = `CCMK_HDR_COUNT;
        mvWdata = {r_reg.hdr[23:16], outLen, r_reg.hdr[7:0], 104'h0};
        if (unitDone) begin
          evCrSet = 1'b1;
          r_next.st = ST_IDLE;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    // Each step starts its unit once on entry and waits for that unit's done pulse.
    mvStart = isMv && !r_reg.go;
    aesStart = isAes && !r_reg.go;
    if ((isMv || isAes) && !r_reg.go) r_next.go = 1'b1;
    if (unitDone) r_next.go = 1'b0;

    evErrSet = mvStall && r_reg.op && (r_reg.st != ST_IDLE);

    if (regWr) begin
      case (regAddr)
        `CCMK_OFS_SHORTCUT: r_next.shortcut = regWdata[0];
        `CCMK_OFS_MODE: begin
          r_next.modeDec = regWdata[`CCMK_MODE_DEC_BIT];
          r_next.modeExt = regWdata[`CCMK_MODE_EXT_BIT];
          r_next.modeWide = regWdata[`CCMK_MODE_WIDE_BIT];
        end
        `CCMK_OFS_CFGPTR: r_next.cfgPtr = regWdata;
        `CCMK_OFS_SCRPTR: r_next.scrPtr = regWdata;
        `CCMK_OFS_INPUT_POINTER: r_next.input_pointer = regWdata;
        `CCMK_OFS_OUTPUT_POINTER: r_next.output_pointer = regWdata;
        `CCMK_OFS_KSLIMIT: begin
          // Larger lengths are clipped so the keystream never passes the largest payload.
          if ((|regWdata[31:8]) || (regWdata[7:0] > `CCMK_KS_MAX_LEN)) begin
            r_next.ksLimit = `CCMK_KS_MAX_LEN;
          end else begin
            r_next.ksLimit = regWdata[7:0];
          end
        end
        default: r_next.shortcut = r_next.shortcut;
      endcase
    end

    // A set in the same cycle as a software clear wins, so no event is lost.
    evWr = regWr && (regAddr == `CCMK_OFS_EVENTS);
    r_next.evKs = evKsSet | (r_reg.evKs & ~(evWr & regWdata[`CCMK_EV_KS_BIT]));
    r_next.evCr = evCrSet | (r_reg.evCr & ~(evWr & regWdata[`CCMK_EV_CIPHER_BIT]));
    r_next.evErr = evErrSet | (r_reg.evErr & ~(evWr & regWdata[`CCMK_EV_ERR_BIT]));

    r_next.rdData = 32'h0;
    if (regRd) begin
      case (regAddr)
        `CCMK_OFS_EVENTS: r_next.rdData = {29'h0, r_reg.evErr, r_reg.evCr, r_reg.evKs};
        `CCMK_OFS_SHORTCUT: r_next.rdData = {31'h0, r_reg.shortcut};
        `CCMK_OFS_MODE: r_next.rdData = {29'h0, r_reg.modeWide, r_reg.modeExt, r_reg.modeDec};
        `CCMK_OFS_CFGPTR: r_next.rdData = r_reg.cfgPtr;
        `CCMK_OFS_SCRPTR: r_next.rdData = r_reg.scrPtr;
        `CCMK_OFS_INPUT_POINTER: r_next.rdData = r_reg.input_pointer;
        `CCMK_OFS_OUTPUT_POINTER: r_next.rdData = r_reg.output_pointer;
        `CCMK_OFS_KSLIMIT: r_next.rdData = {24'h0, r_reg.ksLimit};
        `CCMK_OFS_STATUS: r_next.rdData = {18'h0, r_reg.st};
        default: r_next.rdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) r_reg <= MAIN_RST;
    else r_reg <= r_next;
  end

  assign regRdata = r_reg.rdData;
  assign keystreamDoneEvent = r_reg.evKs;
  assign cipherDoneEvent = r_reg.evCr;
  assign errorEvent = r_reg.evErr;
endmodule

// file: verif/ccmk_monitor.sv
// Port checks for the packet encryptor.
`timescale 1ns/10ps
module ccmk_monitor (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic memGnt,
  input wire logic keystreamDoneEvent,
  input wire logic cipherDoneEvent,
  input wire logic errorEvent
);
  logic clr;
  logic [7:0] waitCnt;
  assign clr = regWr && regAddr == 8'h04;
  // Counts ungranted request cycles; saturates so a long stall cannot wrap.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) waitCnt <= 8'h00;
    else if (!memReq || memGnt) waitCnt <= 8'h00;
    else if (waitCnt != 8'hff) waitCnt <= waitCnt + 8'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_ks_sticky: assert property (
    keystreamDoneEvent && !(clr && regWdata[0]) |=> keystreamDoneEvent) else $error("ks drop");
  a_cr_sticky: assert property (
    cipherDoneEvent && !(clr && regWdata[1]) |=> cipherDoneEvent) else $error("cr drop");
  a_err_sticky: assert property (
    errorEvent && !(clr && regWdata[2]) |=> errorEvent) else $error("err drop");
  a_ks_mem_idle: assert property (
    $rose(keystreamDoneEvent) |-> !$past(memReq)) else $error("ks done busy");
  a_cr_mem_idle: assert property (
    $rose(cipherDoneEvent) |-> !$past(memReq)) else $error("cr done busy");
  a_req_held: assert property (
    memReq && !memGnt |=> memReq && $stable(memAddr) && $stable(memWrite)) else $error("req");
  a_read_gap: assert property (
    memReq && memGnt && !memWrite |=> !memReq) else $error("read gap");
  // The flag shows one edge after the limit, when a late grant may have cleared the count.
  a_err_stall: assert property (
    $rose(errorEvent) |-> $past(waitCnt) >= 8'h40) else $error("early error");
endmodule
bind ccmk_top ccmk_monitor u_mon (.clock, .arst_n, .regAddr, .regWdata, .regWr, .memReq,
  .memWrite, .memAddr, .memGnt, .keystreamDoneEvent, .cipherDoneEvent, .errorEvent);

// file: verif/ccmk_mem_model.sv
// Shared byte memory answering the encryptor's master.
`timescale 1ns/10ps
module ccmk_mem_model (
  input wire logic clock,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [7:0] memWdata,
  input wire logic hold,
  output logic memGnt,
  output logic memRvalid,
  output logic [7:0] memRdata
);
  logic [7:0] mem [0:4095];
  int wrCount;
  logic [31:0] lastWr;
  initial begin
    memGnt = 1'b0;
    memRvalid = 1'b0;
    memRdata = 8'h00;
    wrCount = 0;
    lastWr = 32'h0;
  end
  // Grants come at random; idle read data is inverted so stale bytes never pass.
  always @(posedge clock) begin
    memGnt <= !hold && ($urandom % 4 != 0);
    memRvalid <= memReq && memGnt && !memWrite;
    memRdata <= (memReq && memGnt && !memWrite) ? mem[memAddr[11:0]] : ~memRdata;
    if (memReq && memGnt && memWrite) begin
      mem[memAddr[11:0]] <= memWdata;
      wrCount <= wrCount + 1;
      lastWr <= memAddr;
    end
  end
endmodule

// file: verif/ccm_keystream_packet_encryptor_tb_top.sv
// Self-checking bench for the packet encryptor.
`timescale 1ns/10ps
module ccm_keystream_packet_encryptor_tb_top;
  logic clock, arst_n, regWr, regRd, hold, memReq, memWrite, memGnt, memRvalid;
  logic keystreamDoneEvent, cipherDoneEvent, errorEvent;
  logic [7:0] regAddr, memWdata, memRdata, b, len;
  logic [31:0] regWdata, regRdata, memAddr, d, md;
  logic [2:0] ev;
  int miscompares, tests_run, n;
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hfb, 32'h1};
  assign ev = {errorEvent, cipherDoneEvent, keystreamDoneEvent};
  ccmk_top dut (.clock, .arst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .memReq,
    .memWrite, .memAddr, .memWdata, .memGnt, .memRvalid, .memRdata, .keystreamDoneEvent,
    .cipherDoneEvent, .errorEvent);
  ccmk_mem_model m (.clock, .memReq, .memWrite, .memAddr, .memWdata, .hold, .memGnt,
    .memRvalid, .memRdata);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      miscompares++;
      $display("mismatch at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    regRd <= 1'b0;
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    regWr <= 1'b0;
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdata, x);
  endtask
  task waitEv(input int k);
    regWr <= 1'b0;
    n = 0;
    while (ev[k] !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    chk(ev[k], 1'b1);
  endtask
  task clr;
    wr(8'h04, 32'h7);
    regWr <= 1'b0;
    #1 chk(ev, 3'h0);
  endtask
  // Scratch holds one extra block for the tag pad ahead of the keystream.
  function int ksWr(input logic [31:0] mode, input logic [31:0] lim);
    int l;
    l = mode[1] ? int'(lim) : 27;
    return 16 * ((l + 15) / 16 + 1);
  endfunction
  function logic [7:0] lenOut(input logic [7:0] v, input logic w);
    logic [7:0] k;
    k = w ? 8'hff : 8'h1f;
    return (v & ~k) | ((v + 8'h04) & k);
  endfunction
  initial begin
    #200000;
    miscompares++;
    close_out;
  end
  initial begin
    arst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    hold = 1'b0;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(58140));
    for (int i = 0; i < 4096; i++) m.mem[i] = 8'($urandom);
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 8; i++) rd(8'h08 + 8'(4 * i), rv[i]);
    rd(8'h30, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(8'h10 + 8'(4 * i), d);
      rd(8'h10 + 8'(4 * i), d);
    end
    wr(8'h20, 32'h1fc);
    rd(8'h20, 32'hfb);
    $display("register test done");
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h100);
    wr(8'h18, 32'h400);
    wr(8'h1c, 32'h500);
    for (int i = 0; i < 3; i++) begin
      md = i ? 32'h2 : 32'h0;
      d = (i == 1) ? 32'h21 : 32'h1 + $urandom % 251;
      wr(8'h0c, md);
      wr(8'h20, d);
      m.wrCount = 0;
      wr(8'h00, 32'h1);
      waitEv(0);
      chk(m.wrCount, ksWr(md, d));
      chk(m.lastWr, 32'h100 + ksWr(md, d) - 1);
      clr;
    end
    $display("keystream test done");
    wr(8'h08, 32'h1);
    for (int i = 0; i < 4; i++) begin
      md = i[0] ? 32'h4 : 32'h0;
      len = (i < 2) ? 8'h00 : 8'h01 + 8'($urandom % 27);
      b = md[2] ? len : {3'($urandom), len[4:0]};
      m.mem[12'h401] = b;
      wr(8'h0c, md);
      m.wrCount = 0;
      wr(8'h00, 32'h1);
      waitEv(1);
      chk(m.wrCount, 48 + (len ? len + 7 : 3));
      chk(m.mem[12'h501], len ? lenOut(b, md[2]) : b);
      chk(m.mem[12'h500], m.mem[12'h400]);
      chk(m.lastWr, 32'h502);
      clr;
    end
    $display("cipher test done");
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h2);
    regWr <= 1'b0;
    repeat (300) @(posedge clock);
    chk(ev, 3'h0);
    rd(8'h24, 32'h1);
    wr(8'h0c, 32'h0);
    wr(8'h00, 32'h1);
    waitEv(0);
    wr(8'h00, 32'h2);
    regWr <= 1'b0;
    repeat (10) @(posedge clock);
    hold <= 1'b1;
    repeat (90) @(posedge clock);
    hold <= 1'b0;
    waitEv(1);
    chk(errorEvent, 1'b1);
    rd(8'h04, 32'h7);
    $display("decrypt and stall test done");
    close_out;
  end
endmodule
